/* verilog/ldcr_regs.sv */
// Purpose: logical device configuration register bank
// Assumes: i_hard_reset and i_soft_reset are synchronous one-cycle or level requests
// Notes: read data is registered and stands only in the cycle after the read strobe
`timescale 1ns/10ps

module ldcr_regs
	import ldcr_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_rstn,
	input wire logic i_hard_reset,
	input wire logic i_soft_reset,
	input wire logic [15:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	input wire logic i_uart_irq,
	input wire logic i_midi_irq,
	output logic o_uart_irq_line,
	output logic o_midi_irq_line,
	output logic o_floppy_enhanced,
	output logic o_floppy_nonburst,
	output logic o_floppy_if_at,
	output logic o_floppy_if_second_gen,
	output logic o_floppy_if_model_thirty,
	output logic [7:0] o_drive_types,
	output logic [1:0] o_drive_type_select0,
	output logic [1:0] o_rate_table_select0,
	output logic o_precomp_disable0,
	output logic [1:0] o_drive_type_select1,
	output logic [1:0] o_rate_table_select1,
	output logic o_precomp_disable1,
	output logic [1:0] o_floppy_on_parallel_select,
	output logic o_split_drive_routing,
	output logic o_both_drives_on_parallel,
	output logic o_midi_enable,
	output logic o_high_speed,
	output logic o_share_irq,
	output logic [11:0] o_midi_base
);

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	logic [7:0] ldn;
	logic [7:0] idx;
	logic sel_fm, sel_fo, sel_ft, sel_f3, sel_d0, sel_d1;
	logic sel_pm, sel_p2, sel_sm, sel_mh, sel_ml;

	assign ldn = i_addr[15:8];
	assign idx = i_addr[7:0];

	always_comb
	begin
		sel_fm = 1'b0;
		sel_fo = 1'b0;
		sel_ft = 1'b0;
		sel_f3 = 1'b0;
		sel_d0 = 1'b0;
		sel_d1 = 1'b0;
		sel_pm = 1'b0;
		sel_p2 = 1'b0;
		sel_sm = 1'b0;
		sel_mh = 1'b0;
		sel_ml = 1'b0;
		if (ldn == LDCR_LDN_FLOPPY)
		begin
			if (idx == LDCR_IDX_FLOPPY_MODE)
				sel_fm = 1'b1;
			else if (idx == LDCR_IDX_FLOPPY_OPTION)
				sel_fo = 1'b1;
			else if (idx == LDCR_IDX_FLOPPY_DRIVE_TYPES)
				sel_ft = 1'b1;
			else if (idx == LDCR_IDX_FLOPPY_RESERVED_ZERO)
				sel_f3 = 1'b1;
			else if (idx == LDCR_IDX_FIRST_DRIVE_CONFIG)
				sel_d0 = 1'b1;
			else if (idx == LDCR_IDX_SECOND_DRIVE_CONFIG)
				sel_d1 = 1'b1;
		end
		else if (ldn == LDCR_LDN_PARALLEL)
		begin
			if (idx == LDCR_IDX_PARALLEL_MODE)
				sel_pm = 1'b1;
			else if (idx == LDCR_IDX_PARALLEL_MODE_SECOND)
				sel_p2 = 1'b1;
		end
		else if (ldn == LDCR_LDN_SERIAL)
		begin
			if (idx == LDCR_IDX_SERIAL_MODE)
				sel_sm = 1'b1;
		end
		else if (ldn == LDCR_LDN_MIDI)
		begin
			if (idx == LDCR_IDX_MIDI_BASE_HIGH)
				sel_mh = 1'b1;
			else if (idx == LDCR_IDX_MIDI_BASE_LOW)
				sel_ml = 1'b1;
		end
	end

	// ----------------------------------------
	// storage
	// ----------------------------------------
	logic [7:0] fm_q, fo_q, ft_q, d0_q, d1_q, pm_q, p2_q, sm_q, mh_q, ml_q;

	// hard reset restores defaults; soft reset leaves these alone
	always_ff @(posedge i_ref_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			fm_q <= LDCR_RST_FLOPPY_MODE;
			fo_q <= LDCR_RST_FLOPPY_OPTION;
			ft_q <= LDCR_RST_FLOPPY_DRIVE_TYPES;
			d0_q <= LDCR_RST_DRIVE_CONFIG;
			d1_q <= LDCR_RST_DRIVE_CONFIG;
		end
		else if (i_hard_reset)
		begin
			fm_q <= LDCR_RST_FLOPPY_MODE;
			fo_q <= LDCR_RST_FLOPPY_OPTION;
			ft_q <= LDCR_RST_FLOPPY_DRIVE_TYPES;
			d0_q <= LDCR_RST_DRIVE_CONFIG;
			d1_q <= LDCR_RST_DRIVE_CONFIG;
		end
		else if (i_wr)
		begin
			if (sel_fm)
				fm_q <= i_wdata & LDCR_MASK_FLOPPY_MODE;
			if (sel_fo)
				fo_q <= i_wdata;
			if (sel_ft)
				ft_q <= i_wdata;
			if (sel_d0)
				d0_q <= i_wdata & LDCR_MASK_DRIVE_CONFIG;
			if (sel_d1)
				d1_q <= i_wdata & LDCR_MASK_DRIVE_CONFIG;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			pm_q <= LDCR_RST_PARALLEL_MODE;
			p2_q <= LDCR_RST_PARALLEL_MODE_SECOND;
			sm_q <= LDCR_RST_SERIAL_MODE;
		end
		else if (i_hard_reset)
		begin
			pm_q <= LDCR_RST_PARALLEL_MODE;
			p2_q <= LDCR_RST_PARALLEL_MODE_SECOND;
			sm_q <= LDCR_RST_SERIAL_MODE;
		end
		else if (i_wr)
		begin
			if (sel_pm)
				pm_q <= i_wdata;
			// reserved bits dropped even if software breaks the zero-write duty
			if (sel_p2)
				p2_q <= i_wdata & LDCR_MASK_PARALLEL_MODE_SECOND;
			if (sel_sm)
				sm_q <= i_wdata & LDCR_MASK_SERIAL_MODE;
		end
	end

	// midi base differs: power-on gives zero high byte, hard or soft reset the default
	always_ff @(posedge i_ref_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			mh_q <= LDCR_RST_MIDI_HIGH_POR;
			ml_q <= LDCR_RST_MIDI_LOW;
		end
		else if (i_hard_reset || i_soft_reset)
		begin
			mh_q <= LDCR_RST_MIDI_HIGH_SOFT;
			ml_q <= LDCR_RST_MIDI_LOW;
		end
		else if (i_wr)
		begin
			if (sel_mh)
				mh_q <= i_wdata & LDCR_MASK_MIDI_HIGH;
			if (sel_ml)
				ml_q <= i_wdata & LDCR_MASK_MIDI_LOW;
		end
	end

	// ----------------------------------------
	// read path
	// ----------------------------------------
	logic [7:0] rdata_d;

	always_comb
	begin
		rdata_d = 8'h00;
		if (sel_fm)
			rdata_d = fm_q;
		else if (sel_fo)
			rdata_d = fo_q;
		else if (sel_ft)
			rdata_d = ft_q;
		else if (sel_f3)
			rdata_d = 8'h00;
		else if (sel_d0)
			rdata_d = d0_q;
		else if (sel_d1)
			rdata_d = d1_q;
		else if (sel_pm)
			rdata_d = pm_q;
		else if (sel_p2)
			rdata_d = p2_q;
		else if (sel_sm)
			rdata_d = sm_q;
		else if (sel_mh)
			rdata_d = mh_q;
		else if (sel_ml)
			rdata_d = ml_q;
	end

	// data is valid only after a read; zero otherwise keeps the bus quiet
	always_ff @(posedge i_ref_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			o_rdata <= 8'h00;
		else if (i_rd)
			o_rdata <= rdata_d;
		else
			o_rdata <= 8'h00;
	end

	// ----------------------------------------
	// decoded controls
	// ----------------------------------------
	always_ff @(posedge i_ref_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_floppy_enhanced <= 1'b0;
			o_floppy_nonburst <= 1'b0;
			o_floppy_if_at <= 1'b0;
			o_floppy_if_second_gen <= 1'b0;
			o_floppy_if_model_thirty <= 1'b0;
			o_drive_types <= 8'h00;
		end
		else
		begin
			o_floppy_enhanced <= fm_q[LDCR_FM_ENHANCED_BIT];
			o_floppy_nonburst <= fm_q[LDCR_FM_NONBURST_BIT];
			o_floppy_if_at <= fm_q[LDCR_FM_IF_LSB +: 2] == LDCR_IF_AT;
			o_floppy_if_second_gen <= fm_q[LDCR_FM_IF_LSB +: 2] == LDCR_IF_SECOND_GEN;
			o_floppy_if_model_thirty <= fm_q[LDCR_FM_IF_LSB +: 2] == LDCR_IF_MODEL_THIRTY;
			o_drive_types <= ft_q;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_drive_type_select0 <= 2'h0;
			o_rate_table_select0 <= 2'h0;
			o_precomp_disable0 <= 1'b0;
			o_drive_type_select1 <= 2'h0;
			o_rate_table_select1 <= 2'h0;
			o_precomp_disable1 <= 1'b0;
		end
		else
		begin
			o_drive_type_select0 <= d0_q[LDCR_DC_TYPE_LSB +: 2];
			o_rate_table_select0 <= d0_q[LDCR_DC_RATE_LSB +: 2];
			o_precomp_disable0 <= d0_q[LDCR_DC_PRECOMP_BIT];
			o_drive_type_select1 <= d1_q[LDCR_DC_TYPE_LSB +: 2];
			o_rate_table_select1 <= d1_q[LDCR_DC_RATE_LSB +: 2];
			o_precomp_disable1 <= d1_q[LDCR_DC_PRECOMP_BIT];
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_floppy_on_parallel_select <= 2'h0;
			o_split_drive_routing <= 1'b0;
			o_both_drives_on_parallel <= 1'b0;
			o_midi_enable <= 1'b0;
			o_high_speed <= 1'b0;
			o_share_irq <= 1'b0;
			o_midi_base <= 12'h000;
		end
		else
		begin
			o_floppy_on_parallel_select <= p2_q[1:0];
			o_split_drive_routing <= p2_q[1:0] == LDCR_ROUTE_SPLIT;
			o_both_drives_on_parallel <= p2_q[1:0] == LDCR_ROUTE_BOTH;
			o_midi_enable <= sm_q[LDCR_SM_MIDI_BIT];
			o_high_speed <= sm_q[LDCR_SM_HIGH_SPEED_BIT];
			o_share_irq <= sm_q[LDCR_SM_SHARE_BIT];
			o_midi_base <= {mh_q[3:0], ml_q};
		end
	end

	// ----------------------------------------
	// interrupt sharing
	// ----------------------------------------
	// one register stage of latency; the unassigned line is simply unused by the router
	always_ff @(posedge i_ref_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_uart_irq_line <= 1'b0;
			o_midi_irq_line <= 1'b0;
		end
		else if (sm_q[LDCR_SM_SHARE_BIT])
		begin
			o_uart_irq_line <= i_uart_irq | i_midi_irq;
			o_midi_irq_line <= i_uart_irq | i_midi_irq;
		end
		else
		begin
			o_uart_irq_line <= i_uart_irq;
			o_midi_irq_line <= i_midi_irq;
		end
	end

endmodule // ldcr_regs

/* verilog/ldcr_pkg.sv */
// Purpose: constants for the logical device configuration register bank
// Assumes: address is {logical device number, register index}, 8 bits each
// Notes: masks give the storage bits, other bits read as zero
//
// Operation
// - registers reset on power-on or hard reset; all but MIDI base keep contents through soft reset
// - floppy mode bit 0: clear normal, set enhanced mode 2
// - floppy mode bit 1: clear burst DMA, set non-burst (default)
// - floppy interface field 3:2: 11 AT, 01 second-gen, 00 model-thirty, 10 reserved
// - drive-type register: A in 1:0, B in 3:2, upper fields free storage
// - floppy index F3 is read-only and always reads zero
// - per-drive register: type 1:0, rate table 4:3, bits 2,5,7 read zero
// - per-drive bit 6 set disables write precompensation
// - second drive register matches first drive register in layout and default
// - parallel mode two bits 1:0 route floppy drives to floppy or parallel pins
// - serial mode bit 0 enables MIDI support, default off
// - serial mode bit 1 enables high speed, default off
// - serial mode bit 7 makes serial and MIDI ports share one interrupt
// - share with two lines assigned: both lines assert on either interrupt
// - MIDI base low holds A7..A1, bit 0 zero, default 30 on resets
package ldcr_pkg;

	// ----------------------------------------
	// logical device numbers
	// ----------------------------------------
	localparam logic [7:0] LDCR_LDN_FLOPPY = 8'h00;
	localparam logic [7:0] LDCR_LDN_PARALLEL = 8'h03;
	localparam logic [7:0] LDCR_LDN_SERIAL = 8'h04;
	localparam logic [7:0] LDCR_LDN_MIDI = 8'h05;

	// ----------------------------------------
	// register indices
	// ----------------------------------------
	localparam logic [7:0] LDCR_IDX_MIDI_BASE_HIGH = 8'h60;
	localparam logic [7:0] LDCR_IDX_MIDI_BASE_LOW = 8'h61;
	localparam logic [7:0] LDCR_IDX_FLOPPY_MODE = 8'hF0;
	localparam logic [7:0] LDCR_IDX_PARALLEL_MODE = 8'hF0;
	localparam logic [7:0] LDCR_IDX_SERIAL_MODE = 8'hF0;
	localparam logic [7:0] LDCR_IDX_FLOPPY_OPTION = 8'hF1;
	localparam logic [7:0] LDCR_IDX_PARALLEL_MODE_SECOND = 8'hF1;
	localparam logic [7:0] LDCR_IDX_FLOPPY_DRIVE_TYPES = 8'hF2;
	localparam logic [7:0] LDCR_IDX_FLOPPY_RESERVED_ZERO = 8'hF3;
	localparam logic [7:0] LDCR_IDX_FIRST_DRIVE_CONFIG = 8'hF4;
	localparam logic [7:0] LDCR_IDX_SECOND_DRIVE_CONFIG = 8'hF5;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] LDCR_RST_FLOPPY_MODE = 8'h0E;
	localparam logic [7:0] LDCR_RST_FLOPPY_OPTION = 8'h00;
	localparam logic [7:0] LDCR_RST_FLOPPY_DRIVE_TYPES = 8'hFF;
	localparam logic [7:0] LDCR_RST_DRIVE_CONFIG = 8'h00;
	localparam logic [7:0] LDCR_RST_PARALLEL_MODE = 8'h3C;
	localparam logic [7:0] LDCR_RST_PARALLEL_MODE_SECOND = 8'h00;
	localparam logic [7:0] LDCR_RST_SERIAL_MODE = 8'h00;
	localparam logic [7:0] LDCR_RST_MIDI_HIGH_POR = 8'h00;
	localparam logic [7:0] LDCR_RST_MIDI_HIGH_SOFT = 8'h03;
	localparam logic [7:0] LDCR_RST_MIDI_LOW = 8'h30;

	// ----------------------------------------
	// writable bit masks
	// ----------------------------------------
	localparam logic [7:0] LDCR_MASK_FLOPPY_MODE = 8'hCF;
	localparam logic [7:0] LDCR_MASK_DRIVE_CONFIG = 8'h5B;
	localparam logic [7:0] LDCR_MASK_PARALLEL_MODE_SECOND = 8'h03;
	localparam logic [7:0] LDCR_MASK_SERIAL_MODE = 8'h83;
	localparam logic [7:0] LDCR_MASK_MIDI_HIGH = 8'h0F;
	localparam logic [7:0] LDCR_MASK_MIDI_LOW = 8'hFE;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int LDCR_FM_ENHANCED_BIT = 0;
	localparam int LDCR_FM_NONBURST_BIT = 1;
	localparam int LDCR_FM_IF_LSB = 2;
	localparam int LDCR_DC_TYPE_LSB = 0;
	localparam int LDCR_DC_RATE_LSB = 3;
	localparam int LDCR_DC_PRECOMP_BIT = 6;
	localparam int LDCR_SM_MIDI_BIT = 0;
	localparam int LDCR_SM_HIGH_SPEED_BIT = 1;
	localparam int LDCR_SM_SHARE_BIT = 7;

	// ----------------------------------------
	// floppy interface and routing codes
	// ----------------------------------------
	localparam logic [1:0] LDCR_IF_AT = 2'h3;
	localparam logic [1:0] LDCR_IF_SECOND_GEN = 2'h1;
	localparam logic [1:0] LDCR_IF_MODEL_THIRTY = 2'h0;
	localparam logic [1:0] LDCR_ROUTE_SPLIT = 2'h1;
	localparam logic [1:0] LDCR_ROUTE_BOTH = 2'h2;

endpackage

/* tb/ldcr_regs_properties.sv */
// Purpose: port checker for ldcr_regs
// Assumes: one clock, power-on reset active low
// Notes: decoded outputs lag a register write by one cycle
`timescale 1ns/10ps

module ldcr_regs_chk
(
	input wire logic i_ref_clk,
	input wire logic i_rstn,
	input wire logic i_hard_reset,
	input wire logic i_soft_reset,
	input wire logic [15:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] o_rdata,
	input wire logic i_uart_irq,
	input wire logic i_midi_irq,
	input wire logic o_uart_irq_line,
	input wire logic o_midi_irq_line,
	input wire logic o_floppy_nonburst,
	input wire logic o_floppy_if_at,
	input wire logic [7:0] o_drive_types,
	input wire logic [1:0] o_floppy_on_parallel_select,
	input wire logic o_split_drive_routing,
	input wire logic o_both_drives_on_parallel,
	input wire logic o_midi_enable,
	input wire logic o_high_speed,
	input wire logic o_share_irq,
	input wire logic [11:0] o_midi_base
);
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rstn);
	sequence s_wr_serial;
		i_wr && i_addr == 16'h04F0 && !i_hard_reset;
	endsequence
	// share bit must stand on both sides of the edge, a clear in between is legal
	sequence s_irq_shared;
		o_share_irq && (i_uart_irq || i_midi_irq) ##1 o_share_irq;
	endsequence
	sequence s_irq_apart;
		!o_share_irq ##1 !o_share_irq;
	endsequence
	AST_RDATA_IDLE: assert property (!i_rd |=> o_rdata == 8'h00)
		else $error("read data outside read slot");
	AST_RSVD_F3: assert property (i_rd && i_addr == 16'h00F3 |=> o_rdata == 8'h00)
		else $error("reserved index read not zero");
	AST_PP2_UPPER: assert property (i_rd && i_addr == 16'h03F1 |=> o_rdata[7:2] == 6'h00)
		else $error("routing register upper bits not zero");
	AST_SHARE: assert property (s_irq_shared |-> o_uart_irq_line && o_midi_irq_line)
		else $error("shared interrupt not on both lines");
	AST_APART: assert property (s_irq_apart |-> o_midi_irq_line == $past(i_midi_irq) &&
		o_uart_irq_line == $past(i_uart_irq))
		else $error("separate interrupt lines crossed");
	AST_ROUTE: assert property (o_split_drive_routing == (o_floppy_on_parallel_select == 2'h1)
		&& o_both_drives_on_parallel == (o_floppy_on_parallel_select == 2'h2))
		else $error("drive routing decode wrong");
	AST_MIDI_BIT0: assert property (o_midi_base[0] == 1'h0)
		else $error("midi base bit 0 set");
	AST_WR_SERIAL: assert property (s_wr_serial |-> ##2 {o_share_irq, o_high_speed,
		o_midi_enable} == {$past(i_wdata[7], 2), $past(i_wdata[1:0], 2)})
		else $error("serial mode outputs wrong after write");
	AST_SOFT_KEEP: assert property (i_soft_reset && !i_hard_reset && !i_wr |-> ##2
		$stable(o_drive_types) && $stable(o_share_irq) && o_midi_base == 12'h330)
		else $error("soft reset disturbed registers");
	AST_HARD: assert property (i_hard_reset |-> ##2 o_drive_types == 8'hFF && o_floppy_nonburst
		&& o_floppy_if_at && o_midi_base == 12'h330)
		else $error("hard reset defaults wrong");
endmodule // ldcr_regs_chk

bind ldcr_regs ldcr_regs_chk chk_u (.i_ref_clk, .i_rstn, .i_hard_reset, .i_soft_reset,
	.i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_uart_irq, .i_midi_irq, .o_uart_irq_line,
	.o_midi_irq_line, .o_floppy_nonburst, .o_floppy_if_at, .o_drive_types,
	.o_floppy_on_parallel_select, .o_split_drive_routing, .o_both_drives_on_parallel,
	.o_midi_enable, .o_high_speed, .o_share_irq, .o_midi_base);

/* tb/ldcr_regs_tb_top.sv */
// Purpose: self-checking bench for ldcr_regs
// Assumes: 25 MHz clock, read data in the cycle after the strobe
// Notes: stimulus at rising edge, outputs sampled 1 ns later
`timescale 1ns/10ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
	$display("unexpected at %0t: got %h exp %h", $time, g, e); end end

module ldcr_regs_tb_top;
	logic i_ref_clk = 0, i_rstn = 0, i_hard_reset = 0, i_soft_reset = 0;
	logic i_wr = 0, i_rd = 0, i_uart_irq = 0, i_midi_irq = 0;
	logic [15:0] i_addr = 0;
	logic [7:0] i_wdata = 0, o_rdata, o_drive_types;
	logic o_uart_irq_line, o_midi_irq_line, o_floppy_enhanced, o_floppy_nonburst;
	logic o_floppy_if_at, o_floppy_if_second_gen, o_floppy_if_model_thirty;
	logic [1:0] o_drive_type_select0, o_rate_table_select0, o_drive_type_select1;
	logic [1:0] o_rate_table_select1, o_floppy_on_parallel_select;
	logic o_precomp_disable0, o_precomp_disable1, o_split_drive_routing;
	logic o_both_drives_on_parallel, o_midi_enable, o_high_speed, o_share_irq;
	logic [11:0] o_midi_base;
	int fail_count = 0, tests_run = 0;
	// ----------------------------------------
	// register map: address, reset value, readable mask
	// ----------------------------------------
	logic [15:0] adr [12] = '{16'h0560, 16'h0561, 16'h00F0, 16'h00F1, 16'h00F2, 16'h00F3,
		16'h00F4, 16'h00F5, 16'h03F0, 16'h03F1, 16'h04F0, 16'h0099};
	logic [7:0] rst [12] = '{8'h00, 8'h30, 8'h0E, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h3C,
		8'h00, 8'h00, 8'h00};
	logic [7:0] msk [12] = '{8'h0F, 8'hFE, 8'hCF, 8'hFF, 8'hFF, 8'h00, 8'h5B, 8'h5B, 8'hFF,
		8'h03, 8'h83, 8'h00};

	ldcr_regs dut_u (.i_ref_clk, .i_rstn, .i_hard_reset, .i_soft_reset, .i_addr, .i_wdata,
		.i_wr, .i_rd, .o_rdata, .i_uart_irq, .i_midi_irq, .o_uart_irq_line, .o_midi_irq_line,
		.o_floppy_enhanced, .o_floppy_nonburst, .o_floppy_if_at, .o_floppy_if_second_gen,
		.o_floppy_if_model_thirty, .o_drive_types, .o_drive_type_select0,
		.o_rate_table_select0, .o_precomp_disable0, .o_drive_type_select1,
		.o_rate_table_select1, .o_precomp_disable1, .o_floppy_on_parallel_select,
		.o_split_drive_routing, .o_both_drives_on_parallel, .o_midi_enable, .o_high_speed,
		.o_share_irq, .o_midi_base);

	// ----------------------------------------
	// bus tasks
	// ----------------------------------------
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge i_ref_clk);
		i_wr <= 1'h1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_ref_clk);
		i_wr <= 1'h0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		@(posedge i_ref_clk);
		i_rd <= 1'h1;
		i_addr <= a;
		@(posedge i_ref_clk);
		i_rd <= 1'h0;
		#1 `CHK(o_rdata, e)
	endtask
	// outputs are flops behind the registers, so two edges
	task automatic settle;
		repeat (2) @(posedge i_ref_clk);
		#1;
	endtask
	task automatic give_verdict;
		$display("fail_count=%0d tests_run=%0d", fail_count, tests_run);
		if (fail_count == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial
	begin
		forever #20 i_ref_clk = ~i_ref_clk;
	end
	initial
	begin
		#200000;
		fail_count++;
		give_verdict;
	end
	initial
	begin
		repeat (4) @(posedge i_ref_clk);
		i_rstn <= 1'h1;
		foreach (adr[n]) rd(adr[n], rst[n]);
		foreach (adr[n])
		begin
			wr(adr[n], 8'hFF);
			rd(adr[n], msk[n]);
		end
		for (int c = 0; c < 4; c++)
		begin
			wr(16'h00F0, {4'h0, c[1:0], 2'h1});
			wr(16'h03F1, {6'h00, c[1:0]});
			settle;
			`CHK({o_floppy_enhanced, o_floppy_nonburst}, 2'h2)
			`CHK({o_floppy_if_at, o_floppy_if_second_gen, o_floppy_if_model_thirty},
				{c == 3, c == 1, c == 0})
			`CHK({o_floppy_on_parallel_select, o_split_drive_routing,
				o_both_drives_on_parallel}, {c[1:0], c == 1, c == 2})
		end
		wr(16'h00F4, 8'h41);
		wr(16'h00F5, 8'h1A);
		wr(16'h00F2, 8'hE4);
		settle;
		`CHK({o_drive_type_select0, o_rate_table_select0, o_precomp_disable0,
			o_drive_type_select1, o_rate_table_select1, o_precomp_disable1},
			{2'h1, 2'h0, 1'h1, 2'h2, 2'h3, 1'h0})
		`CHK(o_drive_types, 8'hE4)
		wr(16'h04F0, 8'h03);
		@(posedge i_ref_clk) i_uart_irq <= 1'h1;
		settle;
		`CHK({o_midi_enable, o_high_speed, o_share_irq, o_uart_irq_line,
			o_midi_irq_line}, 5'h1A)
		wr(16'h04F0, 8'h83);
		@(posedge i_ref_clk) {i_uart_irq, i_midi_irq} <= 2'h1;
		settle;
		`CHK({o_share_irq, o_uart_irq_line, o_midi_irq_line}, 3'h7)
		@(posedge i_ref_clk) i_midi_irq <= 1'h0;
		wr(16'h0560, 8'h01);
		wr(16'h0561, 8'h40);
		settle;
		`CHK(o_midi_base, 12'h140)
		@(posedge i_ref_clk) i_soft_reset <= 1'h1;
		@(posedge i_ref_clk) i_soft_reset <= 1'h0;
		rd(16'h00F2, 8'hE4);
		rd(16'h0560, 8'h03);
		rd(16'h0561, 8'h30);
		@(posedge i_ref_clk) i_hard_reset <= 1'h1;
		@(posedge i_ref_clk) i_hard_reset <= 1'h0;
		rd(16'h00F2, 8'hFF);
		rd(16'h04F0, 8'h00);
		wr(16'h0560, 8'h05);
		@(posedge i_ref_clk) i_rstn <= 1'h0;
		@(posedge i_ref_clk) i_rstn <= 1'h1;
		rd(16'h0560, 8'h00);
		give_verdict;
	end
endmodule // ldcr_regs_tb_top
